//--- src/iprt_pkg.sv
// Package with register map, field layout and vector constants for the interrupt priority block.
package iprt_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_TEST_CTRL = 8'h10;
   localparam logic [7:0] IDX_TEST_INJ = 8'h11;
   localparam logic [7:0] IDX_PROMOTE = 8'h1F;
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] ADDR_TEST_CTRL = {IDX_TEST_CTRL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_TEST_INJ = {IDX_TEST_INJ, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_PROMOTE = {IDX_PROMOTE, 2'b00};

   // Test control register fields.
   localparam int TC_BANK_LSB = 0;
   localparam int TC_BANK_W = 4;
   localparam int TC_WEN_BIT = 4;
   localparam logic [4:0] TC_RESET = 5'h00;

   // Bank fifteen keeps only its three lowest test bits.
   localparam logic [3:0] TOP_BANK = 4'hF;
   localparam logic [7:0] TOP_BANK_MASK = 8'h07;
   localparam int BANK_BITS = 8;

   // Promotion register: field is bits 7:1, bit 0 reads as zero.
   localparam logic [6:0] PROMOTE_RESET = 7'h79;
   localparam logic [6:0] PROMOTE_MAX = 7'h79;
   localparam logic [7:0] IRQ_VEC_LO = 8'hF2;

   // Vector address high byte and fixed exception vectors.
   localparam logic [7:0] VEC_HI = 8'hFF;
   localparam logic [7:0] VEC_RESET = 8'hFE;
   localparam logic [7:0] VEC_CLKMON = 8'hFC;
   localparam logic [7:0] VEC_WDOG = 8'hFA;
   localparam logic [7:0] VEC_XIRQ = 8'hF4;
   localparam int NUM_RST = 3;
   localparam int UNTESTABLE_TOP = 5;
endpackage : iprt_pkg

//--- src/iprt_ctrl.sv
// Interrupt priority resolver with promotion register and vector injection test registers.
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module iprt_ctrl #(
   parameter int FIRST_BANK = 8
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [iprt_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor state.
   input wire logic cpu_imask,
   input wire logic cpu_xmask,
   input wire logic special_mode,
   // Request sources.
   input wire logic [iprt_pkg::NUM_RST-1:0] rst_req,
   input wire logic [(16-FIRST_BANK)*8-iprt_pkg::UNTESTABLE_TOP-1:0] periph_req,
   // Vector request to the processor.
   output logic vec_valid,
   output logic [15:0] vec_addr
);
   localparam int NUM_SLOTS = (16 - FIRST_BANK) * 8 - iprt_pkg::UNTESTABLE_TOP;
   localparam int XIRQ_SLOT = NUM_SLOTS - 1;
   localparam int IRQ_SLOT = NUM_SLOTS - 2;
   localparam logic [7:0] BASE_LO = 8'(FIRST_BANK * 16);
   localparam logic [6:0] BASE_SEL = 7'(FIRST_BANK * 8);

   generate
      if (FIRST_BANK < 1 || FIRST_BANK > 15) begin : g_bad_bank
         $error("FIRST_BANK must lie between 1 and 15");
      end
      if (iprt_pkg::NUM_RST != 3) begin : g_bad_rst
         $error("Reset group must hold three requests");
      end
      if (iprt_pkg::BANK_BITS != 8) begin : g_bad_bank_bits
         $error("Each test bank must hold eight bits");
      end
      if (iprt_pkg::ADDR_W < 10) begin : g_bad_addr
         $error("Address must reach the promotion register");
      end
      if (iprt_pkg::TC_WEN_BIT < iprt_pkg::TC_BANK_LSB + iprt_pkg::TC_BANK_W) begin : g_bad_tc
         $error("Test enable bit overlaps the bank selector");
      end
      if (NUM_SLOTS < 2) begin : g_bad_slots
         $error("At least the IRQ and XIRQ slots are needed");
      end
      if (IRQ_SLOT != int'(iprt_pkg::PROMOTE_MAX) - int'(BASE_SEL)) begin : g_bad_promo
         $error("Top promotion value must name the IRQ slot");
      end
      if (iprt_pkg::TOP_BANK != 4'hF) begin : g_bad_top
         $error("Truncated bank must be the last selector");
      end
   endgenerate

   logic [3:0] bank_sel;
   logic test_write_enable;
   logic [6:0] promote_sel;
   logic [NUM_SLOTS-1:0] inject;
   logic [NUM_SLOTS-1:0] eff_req;
   logic test_active;
   logic bank_present;
   logic [7:0] bank_mask;
   logic [7:0] bank_view;
   logic access_done;
   logic setup_access;
   logic addr_hit;
   logic [31:0] next_rdata;
   logic [7:0] next_vec_lo;
   logic next_vec_valid;
   int promo_slot;
   logic promo_valid;
   logic wr_test_ctrl;
   logic wr_test_inj;
   logic wr_promote;
   logic rst_hit;
   logic [7:0] rst_vec_lo;
   logic xirq_hit;
   logic mask_hit;
   logic [7:0] mask_lo;

   typedef enum logic [1:0] {
      IPRT_BUS_IDLE = 2'b00,
      IPRT_BUS_WAIT = 2'b01,
      IPRT_BUS_DONE = 2'b10
   } iprt_bus_t;

   iprt_bus_t bus_state;
   iprt_bus_t next_bus_state;

   assign access_done = psel & penable & pready;
   assign setup_access = (next_bus_state == IPRT_BUS_DONE);
   assign test_active = special_mode & test_write_enable;

   // Write strobes at the completing access cycle.
   always_comb begin
      wr_test_ctrl = 1'b0;
      wr_test_inj = 1'b0;
      wr_promote = 1'b0;
      if (access_done && pwrite) begin
         case (paddr)
            iprt_pkg::ADDR_TEST_CTRL: begin
               wr_test_ctrl = 1'b1;
            end
            iprt_pkg::ADDR_TEST_INJ: begin
               wr_test_inj = 1'b1;
            end
            iprt_pkg::ADDR_PROMOTE: begin
               wr_promote = 1'b1;
            end
            default: begin
               wr_test_ctrl = 1'b0;
            end
         endcase
      end
   end

   // Injection replaces the peripheral lines while test mode is on.
   assign eff_req = test_active ? inject : periph_req;

   // Selected bank decode, including the truncated top bank.
   always_comb begin
      bank_present = (32'(bank_sel) >= FIRST_BANK);
      bank_mask = 8'hFF;
      if (bank_sel == iprt_pkg::TOP_BANK) begin
         bank_mask = iprt_pkg::TOP_BANK_MASK;
      end
      if (!bank_present) begin
         bank_mask = 8'h00;
      end
   end

   // Bank view of the requests reaching the resolver.
   always_comb begin
      int slot;
      slot = 0;
      bank_view = 8'h00;
      for (int i = 0; i < iprt_pkg::BANK_BITS; i++) begin
         slot = (32'(bank_sel) - FIRST_BANK) * 8 + i;
         if (bank_mask[i] && slot >= 0 && slot < NUM_SLOTS) begin
            bank_view[i] = eff_req[slot];
         end
      end
   end

   // Test control register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_sel <= iprt_pkg::TC_RESET[3:0];
         test_write_enable <= iprt_pkg::TC_RESET[4];
      end else if (wr_test_ctrl) begin
         bank_sel <= pwdata[iprt_pkg::TC_BANK_LSB +: iprt_pkg::TC_BANK_W];
         test_write_enable <= pwdata[iprt_pkg::TC_WEN_BIT];
      end
   end

   // Injection registers, one bank of eight slots per selector value from FIRST_BANK up, three slots in bank fifteen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inject <= '0;
      end else if (wr_test_inj && test_active && bank_present) begin
         for (int i = 0; i < iprt_pkg::BANK_BITS; i++) begin
            if (bank_mask[i]) begin
               inject[(32'(bank_sel) - FIRST_BANK) * 8 + i] <= pwdata[i];
            end
         end
      end
   end

   // Promotion register, writable only with maskable interrupts masked.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         promote_sel <= iprt_pkg::PROMOTE_RESET;
      end else if (wr_promote && cpu_imask) begin
         promote_sel <= pwdata[7:1];
      end
   end

   // Map the promotion value to a slot; bad values fall back to IRQ.
   always_comb begin
      promo_valid = (promote_sel >= BASE_SEL) && (promote_sel <= iprt_pkg::PROMOTE_MAX);
      promo_slot = IRQ_SLOT;
      if (promo_valid) begin
         promo_slot = 32'(promote_sel) - 32'(BASE_SEL);
      end
   end

   // Fixed reset group: power, clock monitor, watchdog.
   always_comb begin
      rst_hit = 1'b1;
      rst_vec_lo = 8'h00;
      if (rst_req[0]) begin
         rst_vec_lo = iprt_pkg::VEC_RESET;
      end else if (rst_req[1]) begin
         rst_vec_lo = iprt_pkg::VEC_CLKMON;
      end else if (rst_req[2]) begin
         rst_vec_lo = iprt_pkg::VEC_WDOG;
      end else begin
         rst_hit = 1'b0;
      end
   end

   // Non-maskable request, gated by the X mask only.
   assign xirq_hit = eff_req[XIRQ_SLOT] & ~cpu_xmask;

   // Maskable scan: highest address wins, promoted slot beats all.
   always_comb begin
      mask_hit = 1'b0;
      mask_lo = 8'h00;
      for (int i = 0; i < IRQ_SLOT + 1; i++) begin
         if (eff_req[i]) begin
            mask_hit = 1'b1;
            mask_lo = BASE_LO + 8'(i * 2);
         end
      end
      if (eff_req[promo_slot]) begin
         mask_hit = 1'b1;
         mask_lo = BASE_LO + 8'(promo_slot * 2);
      end
   end

   // Final choice; the I mask gates the maskable group only.
   always_comb begin
      next_vec_valid = 1'b1;
      next_vec_lo = 8'h00;
      if (rst_hit) begin
         next_vec_lo = rst_vec_lo;
      end else if (xirq_hit) begin
         next_vec_lo = iprt_pkg::VEC_XIRQ;
      end else if (mask_hit && !cpu_imask) begin
         next_vec_lo = mask_lo;
      end else begin
         next_vec_valid = 1'b0;
      end
   end

   // Registered vector request to the processor.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_valid <= 1'b0;
         vec_addr <= 16'h0000;
      end else begin
         vec_valid <= next_vec_valid;
         vec_addr <= {iprt_pkg::VEC_HI, next_vec_lo};
      end
   end

   // Read data mux for the APB slave.
   always_comb begin
      next_rdata = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr)
         iprt_pkg::ADDR_TEST_CTRL: begin
            next_rdata[iprt_pkg::TC_BANK_LSB +: iprt_pkg::TC_BANK_W] = bank_sel;
            next_rdata[iprt_pkg::TC_WEN_BIT] = test_write_enable;
         end
         iprt_pkg::ADDR_TEST_INJ: begin
            if (special_mode) begin
               next_rdata[7:0] = bank_view;
            end
         end
         iprt_pkg::ADDR_PROMOTE: begin
            next_rdata[7:0] = {promote_sel, 1'b0};
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end

   // Bus sequencer: setup, one wait state, then the answer cycle.
   always_comb begin
      next_bus_state = bus_state;
      case (bus_state)
         IPRT_BUS_IDLE: begin
            if (psel && penable) begin
               next_bus_state = IPRT_BUS_DONE;
            end else if (psel) begin
               next_bus_state = IPRT_BUS_WAIT;
            end
         end
         IPRT_BUS_WAIT: begin
            if (!psel) begin
               next_bus_state = IPRT_BUS_IDLE;
            end else if (penable) begin
               next_bus_state = IPRT_BUS_DONE;
            end
         end
         IPRT_BUS_DONE: begin
            next_bus_state = (psel && !penable) ? IPRT_BUS_WAIT : IPRT_BUS_IDLE;
         end
         default: begin
            next_bus_state = IPRT_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state <= IPRT_BUS_IDLE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   // One wait state: answer registered in the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (setup_access) begin
         pready <= 1'b1;
         pslverr <= ~addr_hit;
         prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end
endmodule : iprt_ctrl

//--- bench/iprt_ctrl_assertions.sv
// Concurrent checks on the ports of the interrupt priority block.
`timescale 1ns/100ps
module iprt_ctrl_assertions #(parameter int FIRST_BANK = 8) (
   // Clock, reset and register bus.
   input wire logic pclk, input wire logic presetn,
   input wire logic psel, input wire logic penable, input wire logic pwrite,
   input wire logic [iprt_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata, input wire logic pready,
   // Processor state and requests.
   input wire logic cpu_imask, input wire logic cpu_xmask, input wire logic special_mode,
   input wire logic [iprt_pkg::NUM_RST-1:0] rst_req,
   input wire logic [(16-FIRST_BANK)*8-iprt_pkg::UNTESTABLE_TOP-1:0] periph_req,
   input wire logic vec_valid, input wire logic [15:0] vec_addr
);
   localparam int NQ = (16-FIRST_BANK)*8-iprt_pkg::UNTESTABLE_TOP;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rst_top; rst_req[0] |=> vec_valid && vec_addr == 16'hFFFE; endproperty
   a_rst_top: assert property (p_rst_top) else $error("power reset not on top");
   property p_rst_ord; rst_req == 3'h6 |=> vec_valid && vec_addr == 16'hFFFC; endproperty
   a_rst_ord: assert property (p_rst_ord) else $error("reset order wrong");
   property p_xirq;
      !special_mode && rst_req == 3'h0 && !cpu_xmask && periph_req[NQ-1] |=> vec_addr == 16'hFFF4;
   endproperty
   a_xirq: assert property (p_xirq) else $error("xirq not above maskables");
   property p_masked; rst_req == 3'h0 && cpu_imask && cpu_xmask |=> !vec_valid; endproperty
   a_masked: assert property (p_masked) else $error("masked request passed");
   property p_idle; !special_mode && rst_req == 3'h0 && periph_req == '0 |=> !vec_valid; endproperty
   a_idle: assert property (p_idle) else $error("vector without request");
   property p_bit0; pready && !pwrite && paddr == iprt_pkg::ADDR_PROMOTE |-> !prdata[0]; endproperty
   a_bit0: assert property (p_bit0) else $error("promote bit0 set");
   property p_tst;
      pready && !pwrite && paddr == iprt_pkg::ADDR_TEST_INJ && !special_mode |-> prdata == 32'h0;
   endproperty
   a_tst: assert property (p_tst) else $error("test read outside special mode");
   property p_wait; psel && !penable |=> !pready ##1 pready; endproperty
   a_wait: assert property (p_wait) else $error("ready timing wrong");
endmodule : iprt_ctrl_assertions

//--- bench/iprt_src_model.sv
// Model of the processor masks and the peripheral request sources.
`timescale 1ns/100ps
module iprt_src_model #(parameter int NREQ = 59) (
   // Clock.
   input wire logic pclk,
   // Masks and requests.
   output logic cpu_imask, output logic cpu_xmask,
   output logic [iprt_pkg::NUM_RST-1:0] rst_req, output logic [NREQ-1:0] periph_req
);
   initial begin
      {cpu_imask, cpu_xmask, rst_req, periph_req} = {5'h18, {NREQ{1'b0}}};
   end
   // Software sets the I mask before it turns on injection.
   task automatic drive(input logic im, input logic xm, input logic [2:0] r,
      input logic [NREQ-1:0] q);
      @(posedge pclk);
      {cpu_imask, cpu_xmask, rst_req, periph_req} <= {im, xm, r, q};
   endtask : drive
endmodule : iprt_src_model

//--- bench/testbench.sv
// Self-checking bench for the interrupt priority block.
`timescale 1ns/100ps
module testbench;
   localparam int NREQ = 59;
   localparam logic [9:0] AC = iprt_pkg::ADDR_TEST_CTRL, AI = iprt_pkg::ADDR_TEST_INJ;
   localparam logic [9:0] AP = iprt_pkg::ADDR_PROMOTE;
   localparam logic [NREQ-1:0] Q0 = 59'h1, QA = Q0 | (Q0 << 57), QX = QA | (Q0 << 58);
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic special_mode = 1'b0, pready, pslverr, cpu_imask, cpu_xmask, vec_valid, lerr;
   logic [9:0] paddr = 10'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0] rst_req;
   logic [NREQ-1:0] periph_req;
   logic [15:0] vec_addr;
   int err_count = 0, comparisons = 0;
   iprt_ctrl u_iprt_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cpu_imask, .cpu_xmask, .special_mode, .rst_req, .periph_req,
      .vec_valid, .vec_addr);
   iprt_src_model #(.NREQ(NREQ)) u_iprt_src_model (.pclk, .cpu_imask, .cpu_xmask, .rst_req,
      .periph_req);
   initial forever #2.5 pclk = ~pclk;
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      lerr = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic rdc(input logic [9:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk("read", {24'h0, e}, rd);
   endtask : rdc
   task automatic vc(input logic v, input logic [15:0] e);
      repeat (2) @(posedge pclk);
      #1;
      chk("vector", {v, v ? e : 16'h0}, {vec_valid, vec_valid ? vec_addr : 16'h0});
   endtask : vc
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   initial begin
      #5000;
      err_count++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rdc(AP, 8'hF2);
      rdc(AI, 8'h00);
      rdc(10'h3FC, 8'h00);
      chk("slverr", 32'h1, {31'h0, lerr});
      u_iprt_src_model.drive(1'b0, 1'b1, 3'h0, '0);
      apb(1'b1, AP, 8'h81);
      rdc(AP, 8'hF2);
      u_iprt_src_model.drive(1'b1, 1'b1, 3'h0, '0);
      apb(1'b1, AP, 8'h81);
      rdc(AP, 8'h80);
      u_iprt_src_model.drive(1'b0, 1'b1, 3'h0, QA);
      vc(1'b1, 16'hFF80);
      u_iprt_src_model.drive(1'b0, 1'b0, 3'h0, QX);
      vc(1'b1, 16'hFFF4);
      u_iprt_src_model.drive(1'b0, 1'b0, 3'h6, QX);
      vc(1'b1, 16'hFFFC);
      u_iprt_src_model.drive(1'b0, 1'b0, 3'h7, QX);
      vc(1'b1, 16'hFFFE);
      @(posedge pclk);
      special_mode <= 1'b1;
      u_iprt_src_model.drive(1'b1, 1'b0, 3'h0, '0);
      apb(1'b1, AC, 8'h1F);
      apb(1'b1, AI, 8'hFF);
      rdc(AI, 8'h07);
      vc(1'b1, 16'hFFF4);
      apb(1'b1, AC, 8'h13);
      apb(1'b1, AI, 8'hFF);
      rdc(AI, 8'h00);
      apb(1'b1, AC, 8'h18);
      apb(1'b1, AI, 8'h01);
      rdc(AI, 8'h01);
      apb(1'b1, AC, 8'h1F);
      apb(1'b1, AI, 8'h00);
      u_iprt_src_model.drive(1'b1, 1'b0, 3'h0, Q0 << 58);
      vc(1'b0, 16'h0);
      apb(1'b1, AC, 8'h0F);
      rdc(AI, 8'h04);
      apb(1'b1, AI, 8'h07);
      apb(1'b1, AC, 8'h1F);
      rdc(AI, 8'h00);
      close_out();
   end
endmodule : testbench
bind iprt_ctrl iprt_ctrl_assertions #(.FIRST_BANK(FIRST_BANK)) u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .cpu_imask, .cpu_xmask, .special_mode,
   .rst_req, .periph_req, .vec_valid, .vec_addr);
